// ### cbat_pkg.sv
// Constants for the context bank attribute and translation check block.
// Assumes a 32-bit register port with byte addresses and word aligned registers.
package cbat_pkg;
  // Register areas, selected by address bits 11:8
  localparam logic [3:0] AREA_ATTR     = 4'h0;
  localparam logic [3:0] AREA_GLB      = 4'h1;
  localparam logic [3:0] AREA_TCR      = 4'h2;
  // Offsets inside the global area
  localparam logic [7:0] OFS_SCR1      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_MASK      = 8'h08;
  localparam logic [7:0] OFS_CTXFLT    = 8'h0c;
  localparam logic [7:0] OFS_IDENT     = 8'h10;
  // Layout of bank_attribute_reg
  localparam int         ATTR_W        = 24;
  localparam int         VIRTUAL_MACHINE_TAG_LSB      = 0;
  localparam int         VIRTUAL_MACHINE_TAG_W        = 8;
  localparam int         S2B_LSB       = 8;
  localparam int         TYPE_LSB      = 16;
  localparam int         HYPC_BIT      = 18;
  localparam int         MATTR_LSB     = 20;
  localparam int         MATTR_W       = 4;
  // Bank type codes
  localparam logic [1:0] TYPE_S2       = 2'h0;
  localparam logic [1:0] TYPE_S1_BYP   = 2'h1;
  localparam logic [1:0] TYPE_S1_FLT   = 2'h2;
  localparam logic [1:0] TYPE_S1_NEST  = 2'h3;
  // Stage 2 allocation field codes
  localparam logic [1:0] ALLOC_PREV    = 2'h0;
  localparam logic [1:0] ALLOC_RSVD    = 2'h1;
  localparam logic [1:0] ALLOC_YES     = 2'h2;
  localparam logic [1:0] ALLOC_NO      = 2'h3;
  // Position of descriptor bits 63:60 within the 4-bit slice input
  localparam int         WRITE_ALLOC_CFG_LSB     = 2;
  localparam int         READ_ALLOC_CFG_LSB     = 0;
  // Layout of secure_config_reg_one and bank_translation_control_reg
  localparam int         NSNUM_W       = 7;
  localparam int         TCR_W         = 2;
  // Status bits
  localparam int         ST_W          = 4;
  localparam int         ST_INV        = 0;
  localparam int         ST_ASIZE      = 1;
  localparam int         ST_CFG        = 2;
  localparam int         ST_RSVD       = 3;
  // Reset values
  localparam logic [ATTR_W-1:0] ATTR_RST = 24'h000000;
  localparam logic [TCR_W-1:0]  TCR_RST  = 2'h0;
  localparam logic [ST_W-1:0]   ST_RST   = 4'h0;
endpackage : cbat_pkg

// ### cbat_alloc_if.sv
// Interface between the translation check and one allocation hint resolver.
// Assumes the user end drives the hint and field, the resolver answers combinationally.
`timescale 1ns/10ps
interface cbat_alloc_if;
  logic       prev_hint;
  logic [1:0] cfg;
  logic       hint;
  logic       rsvd;
  modport resolver (input prev_hint, input cfg, output hint, output rsvd);
  modport user     (output prev_hint, output cfg, input hint, input rsvd);
endinterface : cbat_alloc_if

// ### cbat_alloc_resolve.sv
// Resolves one stage 2 allocation field against the incoming hint.
// Assumes the caller forces the field to keep-previous when no stage 2 applies.
`timescale 1ns/10ps
module cbat_alloc_resolve (
  cbat_alloc_if.resolver ai
);
  // Field decode; reserved keeps the old hint and is flagged
  always_comb begin
    ai.rsvd = 1'b0;
    unique case (ai.cfg)
      cbat_pkg::ALLOC_PREV: ai.hint = ai.prev_hint;
      cbat_pkg::ALLOC_RSVD: begin
        ai.hint = ai.prev_hint;
        ai.rsvd = 1'b1;
      end
      cbat_pkg::ALLOC_YES:  ai.hint = 1'b1;
      cbat_pkg::ALLOC_NO:   ai.hint = 1'b0;
    endcase
  end
endmodule : cbat_alloc_resolve

// ### cbat_top.sv
// Context bank attribute table with per-transaction translation checks.
// Assumes synchronous inputs on clk_in and a walker that consumes the response.
// Functional notes
// - One attribute register per implemented bank, same index as the bank.
// - Stage 1 attribute may name a second bank for stage 2 when nesting exists.
// - Stage 1 bypass applies no stage 2 but imposes stronger memory attributes.
// - Each bank drives its own context fault interrupt line.
// - Unimplemented attribute access reads zero, or raises a config fault.
// - Non-secure non-hypervisor stage 1 banks tag translations with the machine tag.
// - Cache maintenance through a bank matches on that bank's machine tag.
// - Bank-count override sets which attribute registers non-secure software sees.
// - Secure banks must be stage 1 with bypass; other types raise invalid context.
// - Secure translations never match on the machine tag; visibility is a choice.
// - A selected context triggers a table walk of one or two stages.
// - Descriptor bits 63:62 write-allocate, 61:60 read-allocate, four codes each.
// - Allocate and no-allocate codes override the incoming allocation hint.
// - No legacy memory domain access control in translation.
// - Input and output addresses are checked against implemented sizes.
// - Secure banks may fetch table descriptors from non-secure memory.
// - Two fetch security fields allow non-secure first level fetch, any format.
// - Secure translation becomes non-global if descriptor NS or fetched non-secure.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module cbat_top #(
  parameter int NUM_BANKS      = 8,
  parameter int BW             = 3,
  parameter int IAS            = 40,
  parameter int OAS            = 40,
  parameter bit NESTED_OK      = 1'b1,
  parameter bit UNIMPL_FAULT   = 1'b0,
  parameter bit VIRTUAL_MACHINE_TAG_ON_SECURE = 1'b0
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic [11:0]          reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire logic                 reg_secure_in,
  output logic      [31:0]          reg_rdata_out,
  input  wire logic                 xlat_valid_in,
  input  wire logic [BW-1:0]        xlat_bank_in,
  input  wire logic                 xlat_secure_in,
  input  wire logic [47:0]          xlat_iaddr_in,
  input  wire logic [47:0]          xlat_oaddr_in,
  input  wire logic [3:0]           xlat_s2_desc_hi_in,
  input  wire logic                 xlat_wa_hint_in,
  input  wire logic                 xlat_ra_hint_in,
  input  wire logic [3:0]           xlat_attr_in,
  input  wire logic                 xlat_desc_ns_in,
  input  wire logic                 xlat_fetch_ns_in,
  input  wire logic                 xlat_ng_in,
  input  wire logic                 xlat_ttbr_sel_in,
  output logic                      resp_valid_out,
  output logic                      resp_fault_out,
  output logic      [1:0]           resp_stages_out,
  output logic      [BW-1:0]        resp_s2_bank_out,
  output logic      [7:0]           resp_virtual_machine_tag_out,
  output logic                      resp_match_virtual_machine_tag_out,
  output logic      [3:0]           resp_attr_out,
  output logic                      resp_wa_out,
  output logic                      resp_ra_out,
  output logic                      resp_alloc_rsvd_out,
  output logic                      resp_walk_ns_out,
  output logic                      resp_non_global_out,
  input  wire logic                 maint_valid_in,
  input  wire logic [BW-1:0]        maint_bank_in,
  output logic                      maint_valid_out,
  output logic      [7:0]           maint_virtual_machine_tag_out,
  output logic                      irq_out,
  output logic      [NUM_BANKS-1:0] ctx_irq_out
);
  localparam logic [47:0] IA_MASK = ~((48'h1 << IAS) - 48'h1);
  localparam logic [47:0] OA_MASK = ~((48'h1 << OAS) - 48'h1);
  localparam logic [cbat_pkg::NSNUM_W-1:0] NSNUM_RST = cbat_pkg::NSNUM_W'(NUM_BANKS);

  // Architectural state
  logic [cbat_pkg::ATTR_W-1:0]  attr_q [NUM_BANKS];
  logic [cbat_pkg::TCR_W-1:0]   tcr_q  [NUM_BANKS];
  logic [cbat_pkg::NSNUM_W-1:0] nsnum_q;
  logic [cbat_pkg::ST_W-1:0]    status_q;
  logic [cbat_pkg::ST_W-1:0]    mask_q;
  logic [cbat_pkg::ST_W-1:0]    st_set;
  logic [NUM_BANKS-1:0]         ctx_flt_q;
  logic [NUM_BANKS-1:0]         ctx_set;
  logic [31:0]                  rdata_d;

  // Register decode
  logic [3:0]                   area;
  logic [5:0]                   reg_idx;
  logic                         idx_impl;
  logic                         idx_sec;
  logic                         bank_acc;
  logic                         bank_ok;
  logic                         glb_hit;

  assign area     = reg_addr_in[11:8];
  assign reg_idx  = reg_addr_in[7:2];
  assign idx_impl = ({26'h0, reg_idx} < 32'(NUM_BANKS));
  // Banks at or above the override count belong to the secure world
  assign idx_sec  = ({1'b0, reg_idx} >= nsnum_q);
  assign bank_acc = (area == cbat_pkg::AREA_ATTR) || (area == cbat_pkg::AREA_TCR);
  // Non-secure access to a secure bank is silently read-as-zero
  assign bank_ok  = bank_acc && idx_impl && (reg_secure_in || !idx_sec);
  assign glb_hit  = (area == cbat_pkg::AREA_GLB);

  // Translation decode for the addressed bank
  logic [cbat_pkg::ATTR_W-1:0]  a;
  logic [1:0]                   a_type;
  logic                         a_hyp;
  logic [7:0]                   a_virtual_machine_tag;
  logic [3:0]                   a_mattr;
  logic                         x_impl;
  logic                         x_sec;
  logic                         nested;
  logic                         bypass;
  logic                         inv_ctx;
  logic                         asize_flt;
  logic                         walk_ns;
  logic                         x_fault;

  assign x_impl  = ({{(32-BW){1'b0}}, xlat_bank_in} < 32'(NUM_BANKS));
  assign a       = x_impl ? attr_q[xlat_bank_in] : cbat_pkg::ATTR_RST;
  assign a_type  = a[cbat_pkg::TYPE_LSB +: 2];
  assign a_hyp   = a[cbat_pkg::HYPC_BIT];
  assign a_virtual_machine_tag  = a[cbat_pkg::VIRTUAL_MACHINE_TAG_LSB +: cbat_pkg::VIRTUAL_MACHINE_TAG_W];
  assign a_mattr = a[cbat_pkg::MATTR_LSB +: cbat_pkg::MATTR_W];
  assign x_sec   = (cbat_pkg::NSNUM_W'(xlat_bank_in) >= nsnum_q);
  assign nested  = NESTED_OK && (a_type == cbat_pkg::TYPE_S1_NEST);
  assign bypass  = (a_type == cbat_pkg::TYPE_S1_BYP);

  // Invalid context: secure bank not bypass type, missing bank, fault type on any bank, unsupported nesting
  assign inv_ctx = (x_sec && (a_type != cbat_pkg::TYPE_S1_BYP))
                 || !x_impl
                 || (a_type == cbat_pkg::TYPE_S1_FLT)
                 || (!NESTED_OK && (a_type == cbat_pkg::TYPE_S1_NEST));

  // Both addresses checked; no domain check exists in this path
  assign asize_flt = ((xlat_iaddr_in & IA_MASK) != 48'h0)
                   || ((xlat_oaddr_in & OA_MASK) != 48'h0);
  assign x_fault   = inv_ctx || asize_flt;

  // Secure bank may walk non-secure tables via the selected fetch field
  assign walk_ns = x_sec && x_impl && tcr_q[xlat_bank_in][xlat_ttbr_sel_in];

  // Allocation hint resolvers, one per direction
  cbat_alloc_if wa_if ();
  cbat_alloc_if ra_if ();
  assign wa_if.prev_hint = xlat_wa_hint_in;
  assign ra_if.prev_hint = xlat_ra_hint_in;
  // Without stage 2 the fields carry no meaning
  assign wa_if.cfg = nested ? xlat_s2_desc_hi_in[cbat_pkg::WRITE_ALLOC_CFG_LSB +: 2] : cbat_pkg::ALLOC_PREV;
  assign ra_if.cfg = nested ? xlat_s2_desc_hi_in[cbat_pkg::READ_ALLOC_CFG_LSB +: 2] : cbat_pkg::ALLOC_PREV;

  cbat_alloc_resolve u_wa (
    .ai (wa_if.resolver)
  );
  cbat_alloc_resolve u_ra (
    .ai (ra_if.resolver)
  );

  // Bank attribute table; reset only gives a known value, software must program it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        attr_q[i] <= cbat_pkg::ATTR_RST;
      end
    end else if (reg_wr_in && bank_ok && (area == cbat_pkg::AREA_ATTR)) begin
      attr_q[reg_idx[BW-1:0]] <= reg_wdata_in[cbat_pkg::ATTR_W-1:0];
    end
  end

  // Table fetch security fields per bank
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        tcr_q[i] <= cbat_pkg::TCR_RST;
      end
    end else if (reg_wr_in && bank_ok && (area == cbat_pkg::AREA_TCR)) begin
      tcr_q[reg_idx[BW-1:0]] <= reg_wdata_in[cbat_pkg::TCR_W-1:0];
    end
  end

  // Bank-count override, secure writers only
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nsnum_q <= NSNUM_RST;
    end else if (reg_wr_in && reg_secure_in && glb_hit
                 && (reg_addr_in[7:0] == cbat_pkg::OFS_SCR1)) begin
      nsnum_q <= reg_wdata_in[cbat_pkg::NSNUM_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= cbat_pkg::ST_RST;
    end else if (reg_wr_in && glb_hit && (reg_addr_in[7:0] == cbat_pkg::OFS_MASK)) begin
      mask_q <= reg_wdata_in[cbat_pkg::ST_W-1:0];
    end
  end

  // Status events
  always_comb begin
    st_set = cbat_pkg::ST_RST;
    st_set[cbat_pkg::ST_INV]   = xlat_valid_in && inv_ctx;
    st_set[cbat_pkg::ST_ASIZE] = xlat_valid_in && asize_flt;
    st_set[cbat_pkg::ST_RSVD]  = xlat_valid_in && (wa_if.rsvd || ra_if.rsvd);
    st_set[cbat_pkg::ST_CFG]   = UNIMPL_FAULT && bank_acc && !idx_impl
                               && (reg_wr_in || reg_rd_in);
  end

  // Sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_q <= cbat_pkg::ST_RST;
    end else if (reg_wr_in && glb_hit && (reg_addr_in[7:0] == cbat_pkg::OFS_STATUS)) begin
      status_q <= (status_q & ~reg_wdata_in[cbat_pkg::ST_W-1:0]) | st_set;
    end else begin
      status_q <= status_q | st_set;
    end
  end

  // Per-bank context fault events
  always_comb begin
    ctx_set = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      ctx_set[i] = xlat_valid_in && x_fault && x_impl
                 && ({{(32-BW){1'b0}}, xlat_bank_in} == 32'(i));
    end
  end

  // Per-bank sticky fault, write one to clear, set wins
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctx_flt_q <= '0;
    end else if (reg_wr_in && glb_hit && (reg_addr_in[7:0] == cbat_pkg::OFS_CTXFLT)) begin
      ctx_flt_q <= (ctx_flt_q & ~reg_wdata_in[NUM_BANKS-1:0]) | ctx_set;
    end else begin
      ctx_flt_q <= ctx_flt_q | ctx_set;
    end
  end

  assign ctx_irq_out = ctx_flt_q;
  assign irq_out     = |(status_q & mask_q);

  // Read mux; hidden or missing banks read as zero
  always_comb begin
    rdata_d = 32'h0;
    if (bank_ok && (area == cbat_pkg::AREA_ATTR)) begin
      rdata_d[cbat_pkg::ATTR_W-1:0] = attr_q[reg_idx[BW-1:0]];
    end else if (bank_ok && (area == cbat_pkg::AREA_TCR)) begin
      rdata_d[cbat_pkg::TCR_W-1:0] = tcr_q[reg_idx[BW-1:0]];
    end else if (glb_hit) begin
      unique case (reg_addr_in[7:0])
        cbat_pkg::OFS_SCR1: begin
          if (reg_secure_in) begin
            rdata_d[cbat_pkg::NSNUM_W-1:0] = nsnum_q;
          end
        end
        cbat_pkg::OFS_STATUS: rdata_d[cbat_pkg::ST_W-1:0] = status_q;
        cbat_pkg::OFS_MASK:   rdata_d[cbat_pkg::ST_W-1:0] = mask_q;
        cbat_pkg::OFS_CTXFLT: rdata_d[NUM_BANKS-1:0] = ctx_flt_q;
        // Visible bank count shrinks for non-secure readers
        cbat_pkg::OFS_IDENT: begin
          if (reg_secure_in || (nsnum_q > NSNUM_RST)) begin
            rdata_d[cbat_pkg::NSNUM_W-1:0] = NSNUM_RST;
          end else begin
            rdata_d[cbat_pkg::NSNUM_W-1:0] = nsnum_q;
          end
        end
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_d : 32'h0;
    end
  end

  // Translation response, one cycle after the request
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_valid_out      <= 1'b0;
      resp_fault_out      <= 1'b0;
      resp_stages_out     <= 2'h0;
      resp_s2_bank_out    <= '0;
      resp_virtual_machine_tag_out       <= 8'h00;
      resp_match_virtual_machine_tag_out <= 1'b0;
      resp_attr_out       <= 4'h0;
      resp_wa_out         <= 1'b0;
      resp_ra_out         <= 1'b0;
      resp_alloc_rsvd_out <= 1'b0;
      resp_walk_ns_out    <= 1'b0;
      resp_non_global_out <= 1'b0;
    end else begin
      resp_valid_out   <= xlat_valid_in;
      resp_fault_out   <= xlat_valid_in && x_fault;
      // No walk for a faulting context
      resp_stages_out  <= (!xlat_valid_in || x_fault) ? 2'h0 : (nested ? 2'h2 : 2'h1);
      resp_s2_bank_out <= nested ? a[cbat_pkg::S2B_LSB +: BW] : '0;
      // Tag is shown for secure banks only if chosen, never matched
      resp_virtual_machine_tag_out       <= (!x_sec || VIRTUAL_MACHINE_TAG_ON_SECURE) ? a_virtual_machine_tag : 8'h00;
      resp_match_virtual_machine_tag_out <= xlat_valid_in && !x_sec && !a_hyp;
      // Bypass imposes whichever type is stronger, lower code being stronger
      resp_attr_out <= (bypass && (a_mattr < xlat_attr_in)) ? a_mattr : xlat_attr_in;
      resp_wa_out         <= wa_if.hint;
      resp_ra_out         <= ra_if.hint;
      resp_alloc_rsvd_out <= wa_if.rsvd || ra_if.rsvd;
      resp_walk_ns_out    <= walk_ns;
      // Guards against a secure global entry that maps non-secure memory
      resp_non_global_out <= (xlat_secure_in && (xlat_desc_ns_in || xlat_fetch_ns_in || walk_ns))
                             ? 1'b1 : xlat_ng_in;
    end
  end

  // Maintenance lookup of the issuing bank's tag
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      maint_valid_out <= 1'b0;
      maint_virtual_machine_tag_out  <= 8'h00;
    end else begin
      maint_valid_out <= maint_valid_in;
      maint_virtual_machine_tag_out  <= attr_q[maint_bank_in][cbat_pkg::VIRTUAL_MACHINE_TAG_LSB +: cbat_pkg::VIRTUAL_MACHINE_TAG_W];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_resp_timing: assert property (xlat_valid_in |=> resp_valid_out)
    else $error("response did not follow request");
  a_secure_type: assert property (
    xlat_valid_in && x_sec && (a_type != cbat_pkg::TYPE_S1_BYP)
    |=> resp_fault_out && status_q[cbat_pkg::ST_INV])
    else $error("secure bank with wrong type not faulted");
  a_secure_nomatch: assert property (xlat_valid_in && x_sec |=> !resp_match_virtual_machine_tag_out)
    else $error("secure translation matched on tag");
  a_alloc_override: assert property (xlat_valid_in && nested
    && (xlat_s2_desc_hi_in[cbat_pkg::WRITE_ALLOC_CFG_LSB +: 2] == cbat_pkg::ALLOC_NO) |=> !resp_wa_out)
    else $error("no-allocate code did not override hint");
  a_nonglobal_sec: assert property (xlat_valid_in && xlat_secure_in && xlat_fetch_ns_in
    |=> resp_non_global_out)
    else $error("secure translation left global");
  a_ns_hidden: assert property (reg_rd_in && !reg_secure_in && bank_acc && idx_sec
    |=> reg_rdata_out == 32'h0)
    else $error("secure bank visible to non-secure read");
  a_maint_tag: assert property (maint_valid_in |=> maint_valid_out
    && (maint_virtual_machine_tag_out == $past(attr_q[maint_bank_in][cbat_pkg::VIRTUAL_MACHINE_TAG_LSB +: cbat_pkg::VIRTUAL_MACHINE_TAG_W])))
    else $error("maintenance tag mismatch");
  // Bank index is taken one and two cycles back; the request lines change right after it
  a_ctx_irq_set: assert property (xlat_valid_in && x_fault && x_impl
    |=> ctx_irq_out[$past(xlat_bank_in)]
    ##1 (ctx_irq_out[$past(xlat_bank_in, 2)] || $past(reg_wr_in)))
    else $error("bank interrupt not raised and held");
  a_addr_check: assert property (xlat_valid_in && ((xlat_iaddr_in & IA_MASK) != 48'h0)
    |=> resp_fault_out && (resp_stages_out == 2'h0))
    else $error("oversize input address not faulted");
  a_bypass_attr: assert property (xlat_valid_in && bypass |=> resp_attr_out <= $past(xlat_attr_in))
    else $error("bypass weakened attributes");
endmodule : cbat_top

// ### cbat_master_model.sv
// Upstream master model: issues single translation requests to the block.
// Assumes the bench calls send and reads the answer in the cycle after the pulse.
`timescale 1ns/10ps
module cbat_master_model (
  input  wire logic        clk_in,
  output logic             valid_out,
  output logic [2:0]       bank_out,
  output logic             secure_out,
  output logic [47:0]      iaddr_out,
  output logic [47:0]      oaddr_out,
  output logic [3:0]       desc_hi_out,
  output logic [1:0]       hint_out,
  output logic [3:0]       attr_out,
  output logic [3:0]       flag_out
);
  // Quiet bus at time zero
  initial begin
    valid_out = 1'b0;
    {bank_out, secure_out, iaddr_out, oaddr_out, desc_hi_out, hint_out, attr_out, flag_out} = '0;
  end

  // One-cycle request; idle lines then carry inverted junk so stale values never look valid
  task automatic send(input logic [2:0] b, input logic s, input logic [47:0] ia, oa,
                      input logic [3:0] dh, input logic [1:0] h, input logic [3:0] at, fl);
    @(posedge clk_in);
    valid_out <= 1'b1;
    {bank_out, secure_out, iaddr_out, oaddr_out, desc_hi_out, hint_out, attr_out, flag_out}
      <= {b, s, ia, oa, dh, h, at, fl};
    @(posedge clk_in);
    valid_out <= 1'b0;
    {bank_out, secure_out, iaddr_out, oaddr_out, desc_hi_out, hint_out, attr_out, flag_out}
      <= ~{b, s, ia, oa, dh, h, at, fl};
  endtask : send
endmodule : cbat_master_model

// ### tb_top.sv
// Self-checking bench for the context bank attribute block.
// Assumes default parameters: eight banks, 40-bit address sizes, no unimplemented fault.
`timescale 1ns/10ps
module tb_top;
  logic        clk_in, reset_n_in, reg_wr_in, reg_rd_in, reg_secure_in, maint_valid_in;
  logic        xv, xs, rv, flt, mat, wa, ra, rsv, wns, ng, mv, irq;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [2:0]  xb, maint_bank_in, s2b;
  logic [47:0] ia, oa;
  logic [3:0]  dh, xattr, fl, rattr;
  logic [1:0]  hn, stg;
  logic [7:0]  virtual_machine_tag, mvmid, ctx;
  int          num_errors = 0;
  int          n_tests = 0;

  cbat_top i_cbat_top (
    .clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_secure_in,
    .reg_rdata_out, .xlat_valid_in(xv), .xlat_bank_in(xb), .xlat_secure_in(xs),
    .xlat_iaddr_in(ia), .xlat_oaddr_in(oa), .xlat_s2_desc_hi_in(dh), .xlat_wa_hint_in(hn[1]),
    .xlat_ra_hint_in(hn[0]), .xlat_attr_in(xattr), .xlat_desc_ns_in(fl[3]),
    .xlat_fetch_ns_in(fl[2]), .xlat_ng_in(fl[1]), .xlat_ttbr_sel_in(fl[0]),
    .resp_valid_out(rv), .resp_fault_out(flt), .resp_stages_out(stg), .resp_s2_bank_out(s2b),
    .resp_virtual_machine_tag_out(virtual_machine_tag), .resp_match_virtual_machine_tag_out(mat), .resp_attr_out(rattr), .resp_wa_out(wa),
    .resp_ra_out(ra), .resp_alloc_rsvd_out(rsv), .resp_walk_ns_out(wns),
    .resp_non_global_out(ng), .maint_valid_in, .maint_bank_in, .maint_valid_out(mv),
    .maint_virtual_machine_tag_out(mvmid), .irq_out(irq), .ctx_irq_out(ctx));

  cbat_master_model i_cbat_master_model (
    .clk_in, .valid_out(xv), .bank_out(xb), .secure_out(xs), .iaddr_out(ia), .oaddr_out(oa),
    .desc_hi_out(dh), .hint_out(hn), .attr_out(xattr), .flag_out(fl));

  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic s);
    @(posedge clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in, reg_secure_in} <= {1'b1, a, d, s};
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic s, input logic [31:0] exp);
    @(posedge clk_in);
    {reg_rd_in, reg_addr_in, reg_secure_in} <= {1'b1, a, s};
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk($sformatf("reg %h", a), reg_rdata_out, exp);
  endtask : rd

  task automatic xc(input logic [2:0] b, input logic s, input logic [47:0] a, o,
                    input logic [3:0] d, input logic [1:0] h, input logic [3:0] at, f);
    i_cbat_master_model.send(b, s, a, o, d, h, at, f);
    @(negedge clk_in);
    chk("resp valid", rv, 1'b1);
  endtask : xc

  // Expected hint for one allocation field code
  function automatic logic al(input logic [1:0] c, input logic h);
    return c[1] ? ~c[0] : h;
  endfunction : al

  // Hang guard, far above the hundred or so cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk_in);
    num_errors++;
    results();
  end

  initial begin
    {reg_wr_in, reg_rd_in, reg_secure_in, maint_valid_in, maint_bank_in} = '0;
    {reg_addr_in, reg_wdata_in} = '0;
    reset_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(12'h100, 1'b1, 32'h8);
    rd(12'h110, 1'b0, 32'h8);
    wr(12'h100, 32'h6, 1'b1);
    wr(12'h100, 32'h2, 1'b0);
    rd(12'h100, 1'b1, 32'h6);
    rd(12'h110, 1'b0, 32'h6);
    rd(12'h110, 1'b1, 32'h8);
    // Program banks before any traffic uses them
    wr(12'h008, 32'h030111, 1'b0);
    wr(12'h00c, 32'h31015a, 1'b0);
    wr(12'h018, 32'h010033, 1'b1);
    wr(12'h01c, 32'h020000, 1'b1);
    wr(12'h018, 32'h0, 1'b0);
    rd(12'h018, 1'b0, 32'h0);
    rd(12'h018, 1'b1, 32'h010033);
    rd(12'h00c, 1'b1, 32'h31015a);
    wr(12'h024, 32'hffffff, 1'b1);
    rd(12'h024, 1'b1, 32'h0);
    rd(12'h300, 1'b1, 32'h0);
    // Bypass bank: tag, strengthening, plain global marking
    xc(3'd3, 1'b0, '0, '0, 4'h0, 2'b00, 4'h7, 4'h0);
    chk("bypass", {flt, stg, rattr}, {1'b0, 2'd1, 4'h3});
    chk("tag", {mat, virtual_machine_tag}, 9'h15a);
    // Hypervisor bank keeps its tag off cache matching
    wr(12'h010, 32'h050042, 1'b0);
    xc(3'd4, 1'b0, '0, '0, 4'h0, 2'b00, 4'h0, 4'h0);
    chk("hyp tag", {mat, virtual_machine_tag}, 9'h042);
    xc(3'd3, 1'b0, '0, '0, 4'h0, 2'b00, 4'h2, 4'h8);
    chk("weak attr", {rattr, ng}, {4'h2, 1'b0});
    // Nested bank: every allocation code against both hint values
    for (int h = 0; h < 2; h++)
      for (int c = 0; c < 4; c++) begin
        xc(3'd2, 1'b0, '0, '0, {c[1:0], c[1:0]}, {h[0], ~h[0]}, 4'h5, 4'h0);
        chk("nested", {stg, s2b}, {2'd2, 3'd1});
        chk("alloc", {wa, ra, rsv}, {al(c[1:0], h[0]), al(c[1:0], ~h[0]), c == 1});
      end
    xc(3'd3, 1'b0, 48'h0100_0000_0000, '0, 4'h0, 2'b00, 4'h0, 4'h0);
    chk("iaddr fault", {flt, stg}, 3'b100);
    xc(3'd3, 1'b0, '0, 48'h0100_0000_0000, 4'h0, 2'b00, 4'h0, 4'h0);
    chk("oaddr fault", flt, 1'b1);
    xc(3'd3, 1'b0, 48'h00ff_ffff_ffff, 48'h00ff_ffff_ffff, 4'h0, 2'b00, 4'h0, 4'h0);
    chk("in range", flt, 1'b0);
    chk("masked irq", irq, 1'b0);
    // Secure bank 6 walks table 1 from non-secure memory
    wr(12'h218, 32'h2, 1'b1);
    xc(3'd6, 1'b1, '0, '0, 4'h0, 2'b00, 4'h0, 4'h1);
    chk("secure", {flt, stg, mat, virtual_machine_tag, wns, ng}, {1'b0, 2'd1, 9'h0, 2'b11});
    xc(3'd6, 1'b1, '0, '0, 4'h0, 2'b00, 4'h0, 4'h0);
    chk("secure global", {wns, ng}, 2'b00);
    xc(3'd6, 1'b1, '0, '0, 4'h0, 2'b00, 4'h0, 4'h4);
    chk("fetched ns", ng, 1'b1);
    xc(3'd6, 1'b1, '0, '0, 4'h0, 2'b00, 4'h0, 4'h8);
    chk("desc ns", ng, 1'b1);
    // Illegal secure type raises invalid context and the interrupt
    wr(12'h108, 32'h1, 1'b1);
    xc(3'd7, 1'b1, '0, '0, 4'h0, 2'b00, 4'h0, 4'h0);
    chk("invalid ctx", {flt, stg, irq}, {1'b1, 2'd0, 1'b1});
    chk("ctx lines", ctx, 8'h88);
    rd(12'h104, 1'b1, 32'hb);
    wr(12'h104, 32'h1, 1'b1);
    rd(12'h104, 1'b1, 32'ha);
    chk("irq cleared", irq, 1'b0);
    wr(12'h10c, 32'h80, 1'b1);
    rd(12'h10c, 1'b1, 32'h08);
    chk("ctx cleared", ctx, 8'h08);
    // Back-to-back maintenance through two banks
    @(posedge clk_in);
    {maint_valid_in, maint_bank_in} <= {1'b1, 3'd3};
    @(posedge clk_in);
    maint_bank_in <= 3'd2;
    @(negedge clk_in);
    chk("maint 3", {mv, mvmid}, 9'h15a);
    @(posedge clk_in);
    maint_valid_in <= 1'b0;
    @(negedge clk_in);
    chk("maint 2", {mv, mvmid}, 9'h111);
    results();
  end
endmodule : tb_top
